//--- jrx_map.vh
/*
  Register offsets, field positions, reset values and serial port framing
  for the receiver check and link parameter block.
  Assumes it is included by its bare name from the design files.
*/
// Notes on behaviour
// - The sample check runs only while its enable bit is 1.
// - A writable byte holds the low 8 bits of the reference sample.
// - A writable byte holds the high 8 bits of the reference sample.
// - The reference is compared with the selected demapped receiver sample.
// - Read-only fail flag: set to 1 when a sample differs from reference, held at 1 until cleared.
// - Each set bit x of the invert mask inverts logical lane x data.
// - Device identifier and 4-bit bank identifier from lane 0 read back.
// - Adjustment resolution from lane 0 reads back in bits 7 to 4.
// - Adjustment direction flag from lane 0 reads back in bit 6.
// - Phase adjustment request flag from lane 0 reads back in bit 5.
// - Lane identification from lane 0 reads back in bits 4 to 0.
// - Scrambling status from lane 0 reads back in bit 7, 1 enabled.
// - Lane count minus one from lane 0 reads back in bits 4 to 0.
// - Writing 1 to the check clear bit clears the stored result.
// - A 2-bit converter select picks the checked converter channel.
// - A 2-bit sample select picks the checked sample within the frame.
`ifndef JRX_MAP_VH
`define JRX_MAP_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define JRX_ADDR_W 15
`define JRX_OFS_TPL_CTRL 15'h032C
`define JRX_OFS_REF_LOW 15'h032D
`define JRX_OFS_REF_HIGH 15'h032E
`define JRX_OFS_RESULT 15'h032F
`define JRX_OFS_SETUP 15'h0333
`define JRX_OFS_INVERT 15'h0334
`define JRX_OFS_DEV_IDENT 15'h0400
`define JRX_OFS_ADJ_BANK 15'h0401
`define JRX_OFS_ADJ_LANE 15'h0402
`define JRX_OFS_SCR_LANES 15'h0403

// ****************************************************************
// Field positions
// ****************************************************************
`define JRX_CTRL_ENABLE 0
`define JRX_CTRL_CLEAR 1
`define JRX_CTRL_CONV_LSB 2
`define JRX_CTRL_SAMP_LSB 4
`define JRX_CTRL_MASK 8'h3F
`define JRX_SETUP_REQUIRED 8'h01

// ****************************************************************
// Reset values
// ****************************************************************
`define JRX_RST_BYTE 8'h00
`define JRX_RST_NIBBLE 4'h0
`define JRX_RST_FIVE 5'h00

// ****************************************************************
// Lane 0 alignment octet indices and data shapes
// ****************************************************************
`define JRX_ILA_DEV_IDENT 4'h0
`define JRX_ILA_ADJ_BANK 4'h1
`define JRX_ILA_ADJ_LANE 4'h2
`define JRX_ILA_SCR_LANES 4'h3
`define JRX_LANES 8
`define JRX_OCTET_W 8
`define JRX_SAMPLE_W 16
`define JRX_SLOTS 16

// ****************************************************************
// Serial port framing
// ****************************************************************
`define JRX_SPI_INSTR_BITS 5'd16
`define JRX_SPI_FIRST_SHIFT 5'd17
`define JRX_SPI_FRAME_BITS 5'd24
`define JRX_SPI_LAST_BIT 5'd23
`define JRX_SPI_INSTR_LAST 5'd15

`endif

//--- jrx_regs.v
/*
  Receiver register bank: transport layer sample check, logical lane
  inversion and read-only capture of lane 0 link configuration.
  Assumes lane, sample and alignment inputs come from logic on ref_clk_i;
  only the serial port pins are asynchronous.
*/
`timescale 1ns/100ps
`include "jrx_map.vh"

module jrx_regs (
  // Clock and reset
  input wire ref_clk_i,
  input wire resetn_i,
  // Serial control port
  input wire spi_sclk_i,
  input wire spi_csn_i,
  input wire spi_sdi_i,
  output wire spi_sdo_o,
  output wire spi_sdo_oe_o,
  // Deserialized lanes
  input wire [`JRX_LANES*`JRX_OCTET_W-1:0] lane_data_i,
  input wire lane_valid_i,
  output reg [`JRX_LANES*`JRX_OCTET_W-1:0] lane_data_o,
  output reg lane_valid_o,
  // Lane 0 alignment configuration octets
  input wire ila_cfg_we_i,
  input wire [3:0] ila_cfg_index_i,
  input wire [7:0] ila_cfg_octet_i,
  // Demapped converter samples, slot = converter*4 + sample
  input wire [`JRX_SLOTS*`JRX_SAMPLE_W-1:0] sample_data_i,
  input wire sample_valid_i,
  // Status and setup
  output reg tpl_check_failed_o,
  output wire [7:0] rx_setup_o
);

  wire [`JRX_ADDR_W-1:0] reg_addr;
  wire [7:0] reg_wdata;
  wire reg_wr;
  wire [7:0] reg_rdata;

  reg [7:0] tpl_check_control;
  reg [7:0] tpl_reference_low;
  reg [7:0] tpl_reference_high;
  reg [7:0] receiver_setup_byte;
  reg [7:0] lane_invert_mask;
  reg [7:0] rx_link_device_ident;
  reg [3:0] rx_adjust_resolution;
  reg [3:0] rx_bank_ident;
  reg rx_adjust_direction;
  reg rx_phase_adjust_request;
  reg [4:0] rx_lane_ident;
  reg rx_scramble_status;
  reg [4:0] rx_lane_count;
  reg tpl_check_failed;

  wire tpl_check_enable;
  wire tpl_check_clear;
  wire [1:0] tpl_converter_select;
  wire [1:0] tpl_sample_select;
  wire [3:0] slot_index;
  wire [15:0] selected_sample;
  wire [15:0] reference_sample;
  wire sample_mismatch;
  wire next_failed;

  // ****************************************************************
  // Serial port
  // ****************************************************************
  jrx_spi u_spi (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .spi_sclk_i(spi_sclk_i),
    .spi_csn_i(spi_csn_i),
    .spi_sdi_i(spi_sdi_i),
    .spi_sdo_o(spi_sdo_o),
    .spi_sdo_oe_o(spi_sdo_oe_o),
    .addr_o(reg_addr),
    .wdata_o(reg_wdata),
    .wr_o(reg_wr),
    .rdata_i(reg_rdata)
  );

  // Write strobe for one register offset.
  function wr_hit;
    input strobe;
    input [`JRX_ADDR_W-1:0] addr;
    input [`JRX_ADDR_W-1:0] offset;
    begin
      wr_hit = strobe && (addr == offset);
    end
  endfunction

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tpl_check_control <= `JRX_RST_BYTE;
      tpl_reference_low <= `JRX_RST_BYTE;
      tpl_reference_high <= `JRX_RST_BYTE;
      receiver_setup_byte <= `JRX_RST_BYTE;
      lane_invert_mask <= `JRX_RST_BYTE;
    end else begin
      if (wr_hit(reg_wr, reg_addr, `JRX_OFS_TPL_CTRL)) begin
        tpl_check_control <= reg_wdata & `JRX_CTRL_MASK;
      end
      if (wr_hit(reg_wr, reg_addr, `JRX_OFS_REF_LOW)) begin
        tpl_reference_low <= reg_wdata;
      end
      if (wr_hit(reg_wr, reg_addr, `JRX_OFS_REF_HIGH)) begin
        tpl_reference_high <= reg_wdata;
      end
      if (wr_hit(reg_wr, reg_addr, `JRX_OFS_SETUP)) begin
        receiver_setup_byte <= reg_wdata;
      end
      if (wr_hit(reg_wr, reg_addr, `JRX_OFS_INVERT)) begin
        lane_invert_mask <= reg_wdata;
      end
    end
  end

  // Setup byte is passed to the receiver core, which needs the value 0x1.
  assign rx_setup_o = receiver_setup_byte;

  // ****************************************************************
  // Logical lane inversion
  // ****************************************************************
  genvar lane;
  generate
    for (lane = 0; lane < `JRX_LANES; lane = lane + 1) begin : g_lane
      always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          lane_data_o[lane*`JRX_OCTET_W +: `JRX_OCTET_W] <= `JRX_RST_BYTE;
        end else begin
          lane_data_o[lane*`JRX_OCTET_W +: `JRX_OCTET_W] <=
            lane_data_i[lane*`JRX_OCTET_W +: `JRX_OCTET_W] ^
            {`JRX_OCTET_W{lane_invert_mask[lane]}};
        end
      end
    end
  endgenerate

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      lane_valid_o <= 1'b0;
    end else begin
      lane_valid_o <= lane_valid_i;
    end
  end

  // ****************************************************************
  // Lane 0 link parameter capture
  // ****************************************************************
  // Each field is replaced only when its octet arrives again, so values
  // stay stable between alignment sequences.
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_link_device_ident <= `JRX_RST_BYTE;
      rx_adjust_resolution <= `JRX_RST_NIBBLE;
      rx_bank_ident <= `JRX_RST_NIBBLE;
      rx_adjust_direction <= 1'b0;
      rx_phase_adjust_request <= 1'b0;
      rx_lane_ident <= `JRX_RST_FIVE;
      rx_scramble_status <= 1'b0;
      rx_lane_count <= `JRX_RST_FIVE;
    end else if (ila_cfg_we_i) begin
      case (ila_cfg_index_i)
        `JRX_ILA_DEV_IDENT: begin
          rx_link_device_ident <= ila_cfg_octet_i;
        end
        `JRX_ILA_ADJ_BANK: begin
          rx_adjust_resolution <= ila_cfg_octet_i[7:4];
          rx_bank_ident <= ila_cfg_octet_i[3:0];
        end
        `JRX_ILA_ADJ_LANE: begin
          rx_adjust_direction <= ila_cfg_octet_i[6];
          rx_phase_adjust_request <= ila_cfg_octet_i[5];
          rx_lane_ident <= ila_cfg_octet_i[4:0];
        end
        `JRX_ILA_SCR_LANES: begin
          rx_scramble_status <= ila_cfg_octet_i[7];
          rx_lane_count <= ila_cfg_octet_i[4:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Short transport layer sample check
  // ****************************************************************
  assign tpl_check_enable = tpl_check_control[`JRX_CTRL_ENABLE];
  assign tpl_check_clear = tpl_check_control[`JRX_CTRL_CLEAR];
  assign tpl_converter_select = tpl_check_control[`JRX_CTRL_CONV_LSB +: 2];
  assign tpl_sample_select = tpl_check_control[`JRX_CTRL_SAMP_LSB +: 2];

  assign slot_index = {tpl_converter_select, tpl_sample_select};
  assign selected_sample = sample_data_i[{slot_index, 4'h0} +: `JRX_SAMPLE_W];
  assign reference_sample = {tpl_reference_high, tpl_reference_low};
  assign sample_mismatch = selected_sample != reference_sample;

  // A mismatch seen in the same cycle as a clear still sets the flag.
  assign next_failed = (tpl_check_enable & sample_valid_i & sample_mismatch) |
                       (tpl_check_failed & ~tpl_check_clear);

  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tpl_check_failed <= 1'b0;
      tpl_check_failed_o <= 1'b0;
    end else begin
      tpl_check_failed <= next_failed;
      tpl_check_failed_o <= next_failed;
    end
  end

  // ****************************************************************
  // Read multiplexer
  // ****************************************************************
  function [7:0] rd_mux;
    input [`JRX_ADDR_W-1:0] addr;
    begin
      case (addr)
        `JRX_OFS_TPL_CTRL: rd_mux = tpl_check_control;
        `JRX_OFS_REF_LOW: rd_mux = tpl_reference_low;
        `JRX_OFS_REF_HIGH: rd_mux = tpl_reference_high;
        `JRX_OFS_RESULT: rd_mux = {7'h00, tpl_check_failed};
        `JRX_OFS_SETUP: rd_mux = receiver_setup_byte;
        `JRX_OFS_INVERT: rd_mux = lane_invert_mask;
        `JRX_OFS_DEV_IDENT: rd_mux = rx_link_device_ident;
        `JRX_OFS_ADJ_BANK: rd_mux = {rx_adjust_resolution, rx_bank_ident};
        `JRX_OFS_ADJ_LANE: rd_mux = {1'b0, rx_adjust_direction, rx_phase_adjust_request,
                                     rx_lane_ident};
        `JRX_OFS_SCR_LANES: rd_mux = {rx_scramble_status, 2'h0, rx_lane_count};
        default: rd_mux = 8'h00;
      endcase
    end
  endfunction

  assign reg_rdata = rd_mux(reg_addr);

endmodule

//--- jrx_regs_assertions.sv
/*
  Port checker for the receiver check and link parameter block.
  Assumes it is bound to jrx_regs and sees only that module's ports.
*/
`timescale 1ns/100ps
module jrx_regs_chk (
  // Clock and reset
  input wire ref_clk_i,
  input wire resetn_i,
  // Serial port
  input wire spi_sclk_i,
  input wire spi_csn_i,
  input wire spi_sdo_o,
  input wire spi_sdo_oe_o,
  // Lanes and samples
  input wire [63:0] lane_data_i,
  input wire lane_valid_i,
  input wire [63:0] lane_data_o,
  input wire lane_valid_o,
  input wire sample_valid_i,
  // Status
  input wire tpl_check_failed_o,
  input wire [7:0] rx_setup_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  // Each lane byte is either passed through or fully inverted.
  function automatic logic whole_bytes(input logic [63:0] v);
    integer x;
    whole_bytes = 1'b1;
    for (x = 0; x < 8; x++) begin
      if (v[8*x+:8] != 8'h00 && v[8*x+:8] != 8'hFF) begin
        whole_bytes = 1'b0;
      end
    end
  endfunction

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_lane_invert_bytes: assert property (
    $past(resetn_i) |-> whole_bytes(lane_data_o ^ $past(lane_data_i)))
    else $error("lane output is not a per-lane copy or inverse");
  a_lane_valid_delay: assert property (
    $past(resetn_i) |-> lane_valid_o == $past(lane_valid_i))
    else $error("lane valid is not delayed by one cycle");
  a_fail_needs_sample: assert property (
    $rose(tpl_check_failed_o) |-> $past(sample_valid_i))
    else $error("fail flag rose without a sample");
  a_reset_clean: assert property (
    $rose(resetn_i) |-> !tpl_check_failed_o && rx_setup_o == 8'h00 && !spi_sdo_oe_o)
    else $error("outputs not clear after reset");
  a_setup_held: assert property (
    spi_csn_i [*8] |-> $stable(rx_setup_o))
    else $error("setup byte changed outside a frame");
  a_sdo_idle_off: assert property (
    spi_csn_i [*6] |-> !spi_sdo_oe_o)
    else $error("read data driven while deselected");
  a_sdo_after_instr: assert property (
    $rose(spi_sdo_oe_o) |-> !spi_csn_i && $past(spi_csn_i, 100) == 1'b0)
    else $error("read data driven before the instruction ended");
  a_sdo_bit_stands: assert property (
    spi_sclk_i [*6] ##0 (spi_sdo_oe_o && $past(spi_sdo_oe_o, 2)) |-> $stable(spi_sdo_o))
    else $error("read data changed while serial clock high");

  c_fail_seen: cover property ($rose(tpl_check_failed_o));
  c_read_seen: cover property ($rose(spi_sdo_oe_o));
  c_setup_seen: cover property ($changed(rx_setup_o));
endmodule

bind jrx_regs jrx_regs_chk chk_u (
  .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .spi_sclk_i(spi_sclk_i),
  .spi_csn_i(spi_csn_i), .spi_sdo_o(spi_sdo_o), .spi_sdo_oe_o(spi_sdo_oe_o),
  .lane_data_i(lane_data_i), .lane_valid_i(lane_valid_i), .lane_data_o(lane_data_o),
  .lane_valid_o(lane_valid_o), .sample_valid_i(sample_valid_i),
  .tpl_check_failed_o(tpl_check_failed_o), .rx_setup_o(rx_setup_o));

//--- jrx_spi.v
/*
  Serial control port slave: 16-bit instruction (read flag, 15-bit address)
  followed by one data byte, most significant bit first.
  Assumes the serial clock half period spans at least four reference clocks.
*/
`timescale 1ns/100ps
`include "jrx_map.vh"

module jrx_spi (
  // Clock and reset
  input wire ref_clk_i,
  input wire resetn_i,
  // Serial pins
  input wire spi_sclk_i,
  input wire spi_csn_i,
  input wire spi_sdi_i,
  output wire spi_sdo_o,
  output wire spi_sdo_oe_o,
  // Register side
  output reg [`JRX_ADDR_W-1:0] addr_o,
  output reg [7:0] wdata_o,
  output reg wr_o,
  input wire [7:0] rdata_i
);

  reg [1:0] sclk_sync;
  reg [1:0] csn_sync;
  reg [1:0] sdi_sync;
  reg sclk_prev;
  reg [4:0] bit_cnt;
  reg [14:0] in_shift;
  reg read_mode;
  reg load_pend;
  reg [7:0] out_shift;
  wire sclk_rise;
  wire sclk_fall;

  // ****************************************************************
  // Pin synchronisers and edge detection
  // ****************************************************************
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_sync <= 2'h0;
      csn_sync <= 2'h3;
      sdi_sync <= 2'h0;
      sclk_prev <= 1'b0;
    end else begin
      sclk_sync <= {sclk_sync[0], spi_sclk_i};
      csn_sync <= {csn_sync[0], spi_csn_i};
      sdi_sync <= {sdi_sync[0], spi_sdi_i};
      sclk_prev <= sclk_sync[1];
    end
  end

  assign sclk_rise = sclk_sync[1] & ~sclk_prev;
  assign sclk_fall = ~sclk_sync[1] & sclk_prev;

  // ****************************************************************
  // Frame sequencing
  // ****************************************************************
  always @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bit_cnt <= 5'h00;
      in_shift <= 15'h0000;
      read_mode <= 1'b0;
      load_pend <= 1'b0;
      out_shift <= 8'h00;
      addr_o <= 15'h0000;
      wdata_o <= 8'h00;
      wr_o <= 1'b0;
    end else begin
      wr_o <= 1'b0;
      load_pend <= 1'b0;
      if (csn_sync[1]) begin
        bit_cnt <= 5'h00;
        read_mode <= 1'b0;
      end else begin
        if (sclk_rise && bit_cnt < `JRX_SPI_FRAME_BITS) begin
          bit_cnt <= bit_cnt + 5'd1;
          in_shift <= {in_shift[13:0], sdi_sync[1]};
          if (bit_cnt == `JRX_SPI_INSTR_LAST) begin
            addr_o <= {in_shift[13:0], sdi_sync[1]};
            read_mode <= in_shift[14];
            load_pend <= in_shift[14];
          end
          if (bit_cnt == `JRX_SPI_LAST_BIT && !read_mode) begin
            wdata_o <= {in_shift[6:0], sdi_sync[1]};
            wr_o <= 1'b1;
          end
        end
        if (load_pend) begin
          out_shift <= rdata_i;
        end else if (sclk_fall && bit_cnt >= `JRX_SPI_FIRST_SHIFT) begin
          out_shift <= {out_shift[6:0], 1'b0};
        end
      end
    end
  end

  assign spi_sdo_o = out_shift[7];
  assign spi_sdo_oe_o = read_mode & ~csn_sync[1] & (bit_cnt >= `JRX_SPI_INSTR_BITS);

endmodule

//--- jrx_tx_model.sv
/*
  Transmitter side model: lanes, lane 0 configuration octets, samples.
  Assumes the testbench calls its tasks; idle data shows the inverse.
*/
`timescale 1ns/100ps
module jrx_tx_model (
  // Clock
  input wire ref_clk_i,
  // Lanes
  output logic [63:0] lane_data_o,
  output logic lane_valid_o,
  // Lane 0 configuration
  output logic ila_cfg_we_o,
  output logic [3:0] ila_cfg_index_o,
  output logic [7:0] ila_cfg_octet_o,
  // Samples
  output logic [255:0] sample_data_o,
  output logic sample_valid_o
);
  initial begin
    lane_data_o = 64'h0;
    lane_valid_o = 1'b0;
    ila_cfg_we_o = 1'b0;
    ila_cfg_index_o = 4'hF;
    ila_cfg_octet_o = 8'h00;
    sample_data_o = 256'h0;
    sample_valid_o = 1'b0;
  end
  task send_lanes(input logic [63:0] d);
    @(posedge ref_clk_i) lane_data_o <= d;
    lane_valid_o <= 1'b1;
    @(posedge ref_clk_i) lane_valid_o <= 1'b0;
    lane_data_o <= ~d;
  endtask
  task send_octet(input logic [3:0] i, input logic [7:0] o);
    @(posedge ref_clk_i) ila_cfg_we_o <= 1'b1;
    ila_cfg_index_o <= i;
    ila_cfg_octet_o <= o;
    @(posedge ref_clk_i) ila_cfg_we_o <= 1'b0;
    ila_cfg_index_o <= ~i;
    ila_cfg_octet_o <= ~o;
  endtask
  task send_frame(input logic [3:0] s, input logic [15:0] hit, input logic [15:0] rest);
    logic [255:0] v;
    v = {16{rest}};
    v[16*s+:16] = hit;
    @(posedge ref_clk_i) sample_data_o <= v;
    sample_valid_o <= 1'b1;
    @(posedge ref_clk_i) sample_valid_o <= 1'b0;
    sample_data_o <= ~v;
  endtask
endmodule

//--- test_jesd_rx_tpl_check_and_link_params.sv
/*
  Testbench for jrx_regs: serial port accesses with expected values.
  Assumes the checker is bound and the model drives the link side.
*/
`timescale 1ns/100ps
module test_jesd_rx_tpl_check_and_link_params;
  logic ref_clk_i, resetn_i, spi_sclk, spi_csn, spi_sdi;
  wire spi_sdo, spi_sdo_oe, lane_vin, lane_vout, ila_we, samp_v, fail;
  wire [63:0] lane_in, lane_out;
  wire [3:0] ila_idx;
  wire [7:0] ila_oct, setup;
  wire [255:0] samp;
  integer err_total = 0;
  integer check_count = 0;
  integer k;
  logic [7:0] q;
  logic [3:0] s;
  logic [63:0] exp64;

  jrx_regs dut_u (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .spi_sclk_i(spi_sclk),
    .spi_csn_i(spi_csn), .spi_sdi_i(spi_sdi), .spi_sdo_o(spi_sdo), .spi_sdo_oe_o(spi_sdo_oe),
    .lane_data_i(lane_in), .lane_valid_i(lane_vin), .lane_data_o(lane_out),
    .lane_valid_o(lane_vout), .ila_cfg_we_i(ila_we), .ila_cfg_index_i(ila_idx),
    .ila_cfg_octet_i(ila_oct), .sample_data_i(samp), .sample_valid_i(samp_v),
    .tpl_check_failed_o(fail), .rx_setup_o(setup));
  jrx_tx_model tx_u (.ref_clk_i(ref_clk_i), .lane_data_o(lane_in), .lane_valid_o(lane_vin),
    .ila_cfg_we_o(ila_we), .ila_cfg_index_o(ila_idx), .ila_cfg_octet_o(ila_oct),
    .sample_data_o(samp), .sample_valid_o(samp_v));

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task chk8(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task chk64(input string n, input logic [63:0] e, input logic [63:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // One frame: read flag, 15-bit address, one data byte, MSB first.
  task spi(input logic r, input logic [14:0] a, input logic [7:0] d);
    logic [23:0] f;
    integer i;
    f = {r, a, d};
    @(posedge ref_clk_i) spi_csn <= 1'b0;
    for (i = 23; i >= 0; i--) begin
      spi_sdi <= f[i];
      repeat (8) @(posedge ref_clk_i);
      if (i < 8) q[i] = spi_sdo;
      spi_sclk <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      spi_sclk <= 1'b0;
    end
    repeat (8) @(posedge ref_clk_i);
    spi_csn <= 1'b1;
    repeat (8) @(posedge ref_clk_i);
  endtask
  task wr(input logic [14:0] a, input logic [7:0] d);
    spi(1'b0, a, d);
  endtask
  task rd(input logic [14:0] a, input logic [7:0] e, input string n);
    spi(1'b1, a, 8'h00);
    chk8(n, e, q);
  endtask
  task settle;
    repeat (2) @(posedge ref_clk_i);
    #1;
  endtask

  initial begin
    #400000;
    err_total++;
    $display("BAD watchdog expected finish seen timeout");
    tally_and_finish;
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    resetn_i = 1'b0;
    spi_sclk = 1'b0;
    spi_csn = 1'b1;
    spi_sdi = 1'b0;
    repeat (10) @(posedge ref_clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    rd(15'h032F, 8'h00, "result");
    for (k = 0; k < 4; k++) rd(15'h0400 + k, 8'h00, "link field");
    rd(15'h0500, 8'h00, "unmapped");
    chk8("fail pin", 8'h00, {7'h00, fail});
    $display("test reset done");
    wr(15'h0333, 8'h01);
    rd(15'h0333, 8'h01, "setup");
    chk8("setup pin", 8'h01, setup);
    wr(15'h032D, 8'hA5);
    wr(15'h032E, 8'h3C);
    rd(15'h032D, 8'hA5, "ref low");
    rd(15'h032E, 8'h3C, "ref high");
    wr(15'h032F, 8'hFF);
    rd(15'h032F, 8'h00, "result ro");
    wr(15'h0400, 8'h55);
    rd(15'h0400, 8'h00, "ident ro");
    $display("test access done");
    wr(15'h0334, 8'h5A);
    rd(15'h0334, 8'h5A, "invert mask");
    tx_u.send_lanes(64'h0123456789ABCDEF);
    #1;
    exp64 = 64'h0123456789ABCDEF ^ 64'h00FF00FFFF00FF00;
    chk64("lanes", exp64, lane_out);
    chk8("lane valid", 8'h01, {7'h00, lane_vout});
    $display("test invert done");
    tx_u.send_octet(4'h0, 8'h5C);
    tx_u.send_octet(4'h1, 8'hB7);
    tx_u.send_octet(4'h2, 8'hF5);
    tx_u.send_octet(4'h3, 8'hE1);
    tx_u.send_octet(4'h4, 8'h00);
    rd(15'h0400, 8'h5C, "dev ident");
    rd(15'h0401, 8'hB7, "adj bank");
    rd(15'h0402, 8'h75, "adj lane");
    rd(15'h0403, 8'h81, "scr lanes");
    tx_u.send_octet(4'h0, 8'h3A);
    rd(15'h0400, 8'h3A, "dev ident new");
    rd(15'h0401, 8'hB7, "adj bank held");
    $display("test capture done");
    for (k = 0; k < 4; k++) begin
      s = 4'(k * 5);
      wr(15'h032C, {2'b00, s[1:0], s[3:2], 2'b11});
      wr(15'h032C, {2'b00, s[1:0], s[3:2], 2'b01});
      tx_u.send_frame(s, 16'h3CA5, 16'h0000);
      settle;
      chk8("fail match", 8'h00, {7'h00, fail});
      tx_u.send_frame(s, 16'h3CA4, 16'h3CA5);
      settle;
      chk8("fail differ", 8'h01, {7'h00, fail});
      rd(15'h032F, 8'h01, "result fail");
    end
    wr(15'h032C, 8'h02);
    wr(15'h032C, 8'h00);
    tx_u.send_frame(4'h0, 16'h1111, 16'h2222);
    settle;
    chk8("fail disabled", 8'h00, {7'h00, fail});
    $display("test check done");
    tally_and_finish;
  end
endmodule
